// ===== core/retimer_cfg_pkg.sv
// Constants, field layouts and types shared by the strap configuration logic.
// Assumes strap sensing, the two-wire bus slave and rate detection sit outside.
// Function
// - The device is powered down while the operation enable is low and runs while it is high.
// - A falling edge on the operation enable resets the device.
// - With signal detect enable low the detector is off and input termination stays connected.
// - With signal detect enable high the detector runs and standby follows a missing input clock.
// - In strap mode the de-emphasis strap gives -2 dB when low, 0 dB when open, high reserved.
// - In bus mode de-emphasis comes from the two-wire bus instead of the strap.
// - In strap mode the equalizer strap gives 7.5 dB low, adaptive when open, 14 dB high.
// - In bus mode the equalizer strap is a two-level bus address bit 1.
// - The mode select input chooses bus control mode when high and strap mode when low.
// - In strap mode the strap settings win and bus writes cannot change them.
// - The upper address pin gives bus address bit 2, low by default, open in strap mode.
// - The transmit termination strap disables termination when high, low reserved, open auto.
// - Automatic termination is on above 2 Gbps up to 3.4 Gbps and off below 2 Gbps.
// - The lane strap high inverts receive lane polarity, valid only in retimer operation.
// - The lane strap low swaps receive lane order in both operations; open is normal.
// - Each three-level strap reads high to supply, low to ground and mid when open.
package retimer_cfg_pkg;

  // Decoded level of one strap pin.
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} strap_lvl_type;

  // Raw sense of one strap: pad pulls the pin to supply, to ground, or neither.
  typedef struct packed {
    logic pulled_high;
    logic pulled_low;
  } strap_sense_type;

  // Strap slots in the capture array.
  localparam int STRAP_COUNT = 4;
  localparam int IDX_DEEMPH = 0;
  localparam int IDX_EQ = 1;
  localparam int IDX_TERM = 2;
  localparam int IDX_LANE = 3;

  // Equalizer modes: fixed 7.5 dB, adaptive, fixed 14 dB.
  typedef enum logic [1:0] {EQ_FIXED_LOW_GAIN, EQ_ADAPTIVE, EQ_FIXED_HIGH_GAIN} eq_mode_type;

  // De-emphasis: -2 dB or 0 dB.
  typedef enum logic {DEEMPH_MINUS_2DB, DEEMPH_0DB} deemph_type;

  // Transmit termination: disabled or automatic by data rate.
  typedef enum logic {TERM_NONE, TERM_AUTO} tx_term_type;

  // Settings the two-wire bus may write in bus control mode.
  typedef struct packed {
    deemph_type deemph;
    eq_mode_type eq_mode;
  } bus_cfg_type;

  // Settings delivered to the analog datapath.
  typedef struct packed {
    deemph_type deemph;
    eq_mode_type eq_mode;
    tx_term_type term_mode;
    logic lane_swap;
    logic lane_invert;
  } datapath_cfg_type;

  // Reset values.
  localparam deemph_type DEEMPH_RESET = DEEMPH_0DB;
  localparam eq_mode_type EQ_RESET = EQ_ADAPTIVE;
  localparam tx_term_type TERM_RESET = TERM_AUTO;
  localparam strap_lvl_type LVL_RESET = LVL_MID;
  localparam bus_cfg_type BUS_CFG_RESET = '{deemph: DEEMPH_0DB, eq_mode: EQ_ADAPTIVE};
  localparam datapath_cfg_type DP_CFG_RESET = '{
    deemph: DEEMPH_0DB,
    eq_mode: EQ_ADAPTIVE,
    term_mode: TERM_AUTO,
    lane_swap: 1'b0,
    lane_invert: 1'b0
  };

  // Bus address bits supplied by pins: bit 2 and bit 1.
  localparam int BUS_ADDR_BITS = 2;
  localparam logic [1:0] BUS_ADDR_RESET = 2'h0;

  // Control sequence around the operation enable.
  typedef enum logic [1:0] {ST_POWER_DOWN, ST_CAPTURE, ST_RUN} ctrl_state_type;

endpackage

// ===== core/retimer_strap_config.sv
// Control-pin configuration of the retimer: mode select, strap capture and decode.
// Assumes all inputs are synchronous to mclk and the bus slave lives outside.
`timescale 1ns/100ps
module retimer_strap_config (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Control pins.
  input wire logic op_enable,
  input wire logic bus_mode_sel,
  input wire logic signal_detect_enable,
  // Strap pins as sensed by the pads.
  input wire retimer_cfg_pkg::strap_sense_type deemph_strap,
  input wire retimer_cfg_pkg::strap_sense_type equalizer_strap_addr0,
  input wire retimer_cfg_pkg::strap_sense_type tx_termination_strap,
  input wire retimer_cfg_pkg::strap_sense_type lane_polarity_strap,
  input wire logic upper_addr_bit,
  // Settings written through the two-wire bus slave.
  input wire logic bus_cfg_we,
  input wire retimer_cfg_pkg::bus_cfg_type bus_cfg,
  // Datapath status.
  input wire logic clock_valid,
  input wire logic rate_above_2g,
  input wire logic retimer_active,
  // Power and reset control.
  output retimer_cfg_pkg::ctrl_state_type ctrl_state,
  output logic power_down,
  output logic device_reset_pulse,
  // Signal detect and input termination.
  output logic detector_enable,
  output logic standby,
  output logic rx_term_connect,
  // Datapath settings.
  output retimer_cfg_pkg::datapath_cfg_type dp_cfg,
  output logic tx_term_on,
  output logic strap_reserved,
  // Bus control mode and pin address bits.
  output logic bus_mode,
  output logic [retimer_cfg_pkg::BUS_ADDR_BITS-1:0] bus_addr_bits
);

  // Sequence state and enable history.
  retimer_cfg_pkg::ctrl_state_type state_r;
  retimer_cfg_pkg::ctrl_state_type state_nxt;
  logic op_enable_d_r;
  logic op_enable_d_nxt;
  logic reset_pulse_r;
  logic reset_pulse_nxt;
  logic op_fall;

  // Captured straps.
  retimer_cfg_pkg::strap_sense_type [retimer_cfg_pkg::STRAP_COUNT-1:0] sense_all;
  retimer_cfg_pkg::strap_lvl_type lvl_now [retimer_cfg_pkg::STRAP_COUNT];
  retimer_cfg_pkg::strap_lvl_type lvl_r [retimer_cfg_pkg::STRAP_COUNT];
  retimer_cfg_pkg::strap_lvl_type lvl_nxt [retimer_cfg_pkg::STRAP_COUNT];
  logic mode_r;
  logic mode_nxt;
  logic addr2_r;
  logic addr2_nxt;

  // Bus shadow settings.
  retimer_cfg_pkg::bus_cfg_type shadow_r;
  retimer_cfg_pkg::bus_cfg_type shadow_nxt;

  // Output registers.
  retimer_cfg_pkg::datapath_cfg_type cfg_r;
  retimer_cfg_pkg::datapath_cfg_type cfg_nxt;
  logic pd_r;
  logic pd_nxt;
  logic det_r;
  logic det_nxt;
  logic stby_r;
  logic stby_nxt;
  logic rxt_r;
  logic rxt_nxt;
  logic txt_r;
  logic txt_nxt;
  logic rsv_r;
  logic rsv_nxt;
  logic running;

  assign sense_all[retimer_cfg_pkg::IDX_DEEMPH] = deemph_strap;
  assign sense_all[retimer_cfg_pkg::IDX_EQ] = equalizer_strap_addr0;
  assign sense_all[retimer_cfg_pkg::IDX_TERM] = tx_termination_strap;
  assign sense_all[retimer_cfg_pkg::IDX_LANE] = lane_polarity_strap;

  // One decoder per strap; only the equalizer pin turns two-level, in bus mode.
  genvar gi;
  generate
    for (gi = 0; gi < retimer_cfg_pkg::STRAP_COUNT; gi++) begin : g_strap
      strap_level_decode u_dec (
        .sense(sense_all[gi]),
        .two_level((gi == retimer_cfg_pkg::IDX_EQ) && bus_mode_sel),
        .level(lvl_now[gi])
      );
    end
  endgenerate

  // A falling enable is seen against last cycle's sample, so it always lands as one pulse.
  assign op_fall = op_enable_d_r && !op_enable;
  assign running = (state_r == retimer_cfg_pkg::ST_RUN);

  // Sequence: power down while the enable is low, one capture cycle, then run.
  always_comb begin
    state_nxt = state_r;
    op_enable_d_nxt = op_enable;
    reset_pulse_nxt = op_fall;
    if (!op_enable) begin
      state_nxt = retimer_cfg_pkg::ST_POWER_DOWN;
    end else begin
      unique case (state_r)
        retimer_cfg_pkg::ST_POWER_DOWN: begin
          state_nxt = retimer_cfg_pkg::ST_CAPTURE;
        end
        retimer_cfg_pkg::ST_CAPTURE: begin
          state_nxt = retimer_cfg_pkg::ST_RUN;
        end
        retimer_cfg_pkg::ST_RUN: begin
          state_nxt = retimer_cfg_pkg::ST_RUN;
        end
        default: begin
          state_nxt = retimer_cfg_pkg::ST_POWER_DOWN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= retimer_cfg_pkg::ST_POWER_DOWN;
      op_enable_d_r <= 1'b0;
      reset_pulse_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      op_enable_d_r <= op_enable_d_nxt;
      reset_pulse_r <= reset_pulse_nxt;
    end
  end

  // Straps and mode are taken in the capture cycle only; later pin changes are ignored.
  // Holding them avoids a glitching strap retuning the analog path mid-stream.
  always_comb begin
    mode_nxt = mode_r;
    addr2_nxt = addr2_r;
    for (int i = 0; i < retimer_cfg_pkg::STRAP_COUNT; i++) begin
      lvl_nxt[i] = lvl_r[i];
    end
    if (op_fall) begin
      mode_nxt = 1'b0;
      addr2_nxt = 1'b0;
      for (int i = 0; i < retimer_cfg_pkg::STRAP_COUNT; i++) begin
        lvl_nxt[i] = retimer_cfg_pkg::LVL_RESET;
      end
    end else if (state_r == retimer_cfg_pkg::ST_CAPTURE) begin
      mode_nxt = bus_mode_sel;
      addr2_nxt = upper_addr_bit;
      for (int i = 0; i < retimer_cfg_pkg::STRAP_COUNT; i++) begin
        lvl_nxt[i] = lvl_now[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= 1'b0;
      addr2_r <= 1'b0;
      for (int i = 0; i < retimer_cfg_pkg::STRAP_COUNT; i++) begin
        lvl_r[i] <= retimer_cfg_pkg::LVL_RESET;
      end
    end else if (ce) begin
      mode_r <= mode_nxt;
      addr2_r <= addr2_nxt;
      for (int i = 0; i < retimer_cfg_pkg::STRAP_COUNT; i++) begin
        lvl_r[i] <= lvl_nxt[i];
      end
    end
  end

  // Bus writes land only while running in bus mode; in strap mode they are dropped.
  always_comb begin
    shadow_nxt = shadow_r;
    if (op_fall) begin
      shadow_nxt = retimer_cfg_pkg::BUS_CFG_RESET;
    end else if (running && mode_r && bus_cfg_we) begin
      shadow_nxt = bus_cfg;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shadow_r <= retimer_cfg_pkg::BUS_CFG_RESET;
    end else if (ce) begin
      shadow_r <= shadow_nxt;
    end
  end

  // Datapath settings from the held straps or, in bus mode, de-emphasis and equalizer from the bus shadow.
  always_comb begin
    cfg_nxt = retimer_cfg_pkg::DP_CFG_RESET;
    rsv_nxt = 1'b0;
    if (mode_r) begin
      cfg_nxt.deemph = shadow_r.deemph;
      cfg_nxt.eq_mode = shadow_r.eq_mode;
    end else begin
      unique case (lvl_r[retimer_cfg_pkg::IDX_DEEMPH])
        retimer_cfg_pkg::LVL_LOW: cfg_nxt.deemph = retimer_cfg_pkg::DEEMPH_MINUS_2DB;
        retimer_cfg_pkg::LVL_MID: cfg_nxt.deemph = retimer_cfg_pkg::DEEMPH_0DB;
        retimer_cfg_pkg::LVL_HIGH: begin
          // Reserved level falls back to no de-emphasis and is flagged.
          cfg_nxt.deemph = retimer_cfg_pkg::DEEMPH_0DB;
          rsv_nxt = 1'b1;
        end
        default: cfg_nxt.deemph = retimer_cfg_pkg::DEEMPH_RESET;
      endcase
      unique case (lvl_r[retimer_cfg_pkg::IDX_EQ])
        retimer_cfg_pkg::LVL_LOW: cfg_nxt.eq_mode = retimer_cfg_pkg::EQ_FIXED_LOW_GAIN;
        retimer_cfg_pkg::LVL_MID: cfg_nxt.eq_mode = retimer_cfg_pkg::EQ_ADAPTIVE;
        retimer_cfg_pkg::LVL_HIGH: cfg_nxt.eq_mode = retimer_cfg_pkg::EQ_FIXED_HIGH_GAIN;
        default: cfg_nxt.eq_mode = retimer_cfg_pkg::EQ_RESET;
      endcase
    end
    unique case (lvl_r[retimer_cfg_pkg::IDX_TERM])
      retimer_cfg_pkg::LVL_HIGH: cfg_nxt.term_mode = retimer_cfg_pkg::TERM_NONE;
      retimer_cfg_pkg::LVL_MID: cfg_nxt.term_mode = retimer_cfg_pkg::TERM_AUTO;
      retimer_cfg_pkg::LVL_LOW: begin
        // Reserved level keeps automatic mode and is flagged.
        cfg_nxt.term_mode = retimer_cfg_pkg::TERM_AUTO;
        rsv_nxt = 1'b1;
      end
      default: cfg_nxt.term_mode = retimer_cfg_pkg::TERM_RESET;
    endcase
    cfg_nxt.lane_swap = (lvl_r[retimer_cfg_pkg::IDX_LANE] == retimer_cfg_pkg::LVL_LOW);
    // Polarity inversion is only honoured while the clock recovery path is in use.
    cfg_nxt.lane_invert = (lvl_r[retimer_cfg_pkg::IDX_LANE] == retimer_cfg_pkg::LVL_HIGH)
                          && retimer_active;
  end

  // Power, signal detect and termination controls.
  always_comb begin
    pd_nxt = !running;
    det_nxt = signal_detect_enable && running;
    stby_nxt = signal_detect_enable && running && !clock_valid;
    // With signal detect enable low the input termination never drops, even in power down.
    rxt_nxt = !signal_detect_enable || (running && clock_valid);
    // The rate flag covers 2 Gbps up to the 3.4 Gbps ceiling of the link.
    txt_nxt = running && (cfg_r.term_mode == retimer_cfg_pkg::TERM_AUTO)
              && rate_above_2g;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= retimer_cfg_pkg::DP_CFG_RESET;
      rsv_r <= 1'b0;
      pd_r <= 1'b1;
      det_r <= 1'b0;
      stby_r <= 1'b0;
      rxt_r <= 1'b1;
      txt_r <= 1'b0;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      rsv_r <= rsv_nxt;
      pd_r <= pd_nxt;
      det_r <= det_nxt;
      stby_r <= stby_nxt;
      rxt_r <= rxt_nxt;
      txt_r <= txt_nxt;
    end
  end

  // Bus address bits: bit 2 from the upper pin, bit 1 from the equalizer pin in bus mode.
  logic [retimer_cfg_pkg::BUS_ADDR_BITS-1:0] addr_r;
  logic [retimer_cfg_pkg::BUS_ADDR_BITS-1:0] addr_nxt;
  logic bus_mode_r;
  logic bus_mode_nxt;

  always_comb begin
    bus_mode_nxt = mode_r && running;
    addr_nxt = retimer_cfg_pkg::BUS_ADDR_RESET;
    if (mode_r) begin
      addr_nxt = {addr2_r, lvl_r[retimer_cfg_pkg::IDX_EQ] == retimer_cfg_pkg::LVL_HIGH};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_mode_r <= 1'b0;
      addr_r <= retimer_cfg_pkg::BUS_ADDR_RESET;
    end else if (ce) begin
      bus_mode_r <= bus_mode_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Every output is a flip-flop.
  assign ctrl_state = state_r;
  assign power_down = pd_r;
  assign device_reset_pulse = reset_pulse_r;
  assign detector_enable = det_r;
  assign standby = stby_r;
  assign rx_term_connect = rxt_r;
  assign dp_cfg = cfg_r;
  assign tx_term_on = txt_r;
  assign strap_reserved = rsv_r;
  assign bus_mode = bus_mode_r;
  assign bus_addr_bits = addr_r;

endmodule

// ===== core/strap_level_decode.sv
// Decoder from the pad sense of one strap pin to a strap level.
// Assumes the sense bits are stable and synchronous to the clock.
`timescale 1ns/100ps
module strap_level_decode (
  // Pad sense and decode style.
  input wire retimer_cfg_pkg::strap_sense_type sense,
  input wire logic two_level,
  // Decoded level.
  output retimer_cfg_pkg::strap_lvl_type level
);

  // Both pulls sensed at once cannot come from a strap resistor, so a three-level pin reads it as open.
  always_comb begin
    if (two_level) begin
      // A two-level pin is high only when pulled to supply.
      level = sense.pulled_high ? retimer_cfg_pkg::LVL_HIGH : retimer_cfg_pkg::LVL_LOW;
    end else if (sense.pulled_high && !sense.pulled_low) begin
      level = retimer_cfg_pkg::LVL_HIGH;
    end else if (sense.pulled_low && !sense.pulled_high) begin
      level = retimer_cfg_pkg::LVL_LOW;
    end else begin
      level = retimer_cfg_pkg::LVL_MID;
    end
  end

endmodule

// ===== dv/retimer_strap_config_sva.sv
// Checker for the strap configuration block, bound to its top module.
// Assumes one clock domain; the bench drops ce on even passes, so all relations except p_hold and p_addr sample ce.
`timescale 1ns/100ps
module retimer_strap_config_sva (
  // Clock, reset and inputs.
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic op_enable,
  input wire logic signal_detect_enable,
  input wire logic bus_cfg_we,
  input wire retimer_cfg_pkg::bus_cfg_type bus_cfg,
  input wire logic clock_valid,
  input wire logic rate_above_2g,
  // Watched outputs.
  input wire retimer_cfg_pkg::ctrl_state_type ctrl_state,
  input wire logic power_down,
  input wire logic device_reset_pulse,
  input wire logic detector_enable,
  input wire logic standby,
  input wire logic rx_term_connect,
  input wire retimer_cfg_pkg::datapath_cfg_type dp_cfg,
  input wire logic tx_term_on,
  input wire logic bus_mode,
  input wire logic [1:0] bus_addr_bits
);
  logic run;

  // Running state, used by most relations below.
  assign run = ctrl_state == retimer_cfg_pkg::ST_RUN;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Two running samples mean the captured settings have reached the outputs.
  sequence s_run2;
    run ##1 run;
  endsequence
  sequence s_write;
    run && bus_mode && bus_cfg_we && ce;
  endsequence

  property p_pd;
    (ce && !op_enable) [*2] |=> power_down;
  endproperty
  a_pd: assert property (p_pd) else $error("power down not entered");
  property p_run;
    run && ce |=> !power_down;
  endproperty
  a_run: assert property (p_run) else $error("power down while running");
  property p_pulse;
    $fell(op_enable) && ce && ctrl_state != retimer_cfg_pkg::ST_POWER_DOWN
      |=> device_reset_pulse ##1 !device_reset_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse wrong");
  property p_det_off;
    !signal_detect_enable && ce |=> rx_term_connect && !detector_enable;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector off wrong");
  property p_standby;
    signal_detect_enable && !clock_valid && run && ce
      |=> standby && detector_enable && !rx_term_connect;
  endproperty
  a_standby: assert property (p_standby) else $error("standby missing");
  property p_hold;
    s_run2 ##0 !bus_mode |=> $stable({dp_cfg.deemph, dp_cfg.eq_mode, dp_cfg.term_mode,
      dp_cfg.lane_swap});
  endproperty
  a_hold: assert property (p_hold) else $error("strap settings moved");
  property p_addr;
    s_run2 ##0 !bus_mode |-> bus_addr_bits == 2'h0;
  endproperty
  a_addr: assert property (p_addr) else $error("address bits in strap mode");
  property p_tx_on;
    run && dp_cfg.term_mode == retimer_cfg_pkg::TERM_AUTO && rate_above_2g && ce
      |=> tx_term_on;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx termination off");
  property p_tx_off;
    (!rate_above_2g || dp_cfg.term_mode == retimer_cfg_pkg::TERM_NONE) && ce |=> !tx_term_on;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx termination on");
  property p_bus_wr;
    s_write ##1 (run && !bus_cfg_we) ##1 run |=> dp_cfg.deemph == $past(bus_cfg.deemph, 3)
      && dp_cfg.eq_mode == $past(bus_cfg.eq_mode, 3);
  endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("bus write not applied");
endmodule

bind retimer_strap_config retimer_strap_config_sva retimer_strap_config_sva_i (
  .mclk(mclk), .nrst(nrst), .ce(ce), .op_enable(op_enable),
  .signal_detect_enable(signal_detect_enable), .bus_cfg_we(bus_cfg_we), .bus_cfg(bus_cfg),
  .clock_valid(clock_valid), .rate_above_2g(rate_above_2g), .ctrl_state(ctrl_state),
  .power_down(power_down), .device_reset_pulse(device_reset_pulse),
  .detector_enable(detector_enable), .standby(standby), .rx_term_connect(rx_term_connect),
  .dp_cfg(dp_cfg), .tx_term_on(tx_term_on), .bus_mode(bus_mode), .bus_addr_bits(bus_addr_bits)
);

// ===== dv/retimer_strap_config_tb.sv
// Self-checking bench for the strap configuration block.
// Assumes the board model and checker files are compiled before this one.
`timescale 1ns/100ps
module retimer_strap_config_tb;
  logic mclk, nrst, ce, op_enable, bus_mode_sel, signal_detect_enable, upper_addr_bit;
  logic bus_cfg_we, clock_valid, rate_above_2g, retimer_active, addr_drive, addr_val;
  retimer_cfg_pkg::bus_cfg_type bus_cfg, sh, w;
  retimer_cfg_pkg::strap_lvl_type lvl [4];
  retimer_cfg_pkg::strap_sense_type sense [4];
  retimer_cfg_pkg::ctrl_state_type ctrl_state;
  retimer_cfg_pkg::datapath_cfg_type dp_cfg;
  logic power_down, device_reset_pulse, detector_enable, standby, rx_term_connect;
  logic tx_term_on, strap_reserved, bus_mode, m, a;
  logic [1:0] bus_addr_bits;
  int l [4];
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  retimer_strap_config retimer_strap_config_i (
    .mclk(mclk), .nrst(nrst), .ce(ce), .op_enable(op_enable), .bus_mode_sel(bus_mode_sel),
    .signal_detect_enable(signal_detect_enable), .deemph_strap(sense[0]),
    .equalizer_strap_addr0(sense[1]), .tx_termination_strap(sense[2]),
    .lane_polarity_strap(sense[3]), .upper_addr_bit(upper_addr_bit), .bus_cfg_we(bus_cfg_we),
    .bus_cfg(bus_cfg), .clock_valid(clock_valid), .rate_above_2g(rate_above_2g),
    .retimer_active(retimer_active), .ctrl_state(ctrl_state), .power_down(power_down),
    .device_reset_pulse(device_reset_pulse), .detector_enable(detector_enable),
    .standby(standby), .rx_term_connect(rx_term_connect), .dp_cfg(dp_cfg),
    .tx_term_on(tx_term_on), .strap_reserved(strap_reserved), .bus_mode(bus_mode),
    .bus_addr_bits(bus_addr_bits)
  );
  strap_board_model strap_board_model_i (
    .mclk(mclk), .lvl(lvl), .addr_drive(addr_drive), .addr_val(addr_val), .sense(sense),
    .upper_addr_bit(upper_addr_bit)
  );

  // Free-running 200 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Levels index the enums directly, since both list low, mid, high in order.
  function automatic logic [14:0] expect_out();
    retimer_cfg_pkg::datapath_cfg_type d;
    d.deemph = m ? sh.deemph : retimer_cfg_pkg::deemph_type'(l[0] != 0);
    d.eq_mode = m ? sh.eq_mode : retimer_cfg_pkg::eq_mode_type'(l[1]);
    d.term_mode = retimer_cfg_pkg::tx_term_type'(l[2] != 2);
    d.lane_swap = l[3] == 0;
    d.lane_invert = l[3] == 2 && retimer_active;
    return {d, d.term_mode == retimer_cfg_pkg::TERM_AUTO && rate_above_2g,
      (!m && l[0] == 2) || l[2] == 0, m, m ? {a, l[1] == 2} : 2'h0, 1'b0,
      signal_detect_enable, signal_detect_enable && !clock_valid,
      !signal_detect_enable || clock_valid};
  endfunction

  // Hang guard, far above the expected run length.
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      results();
    end
  end

  // Main sequence: corner passes first, then random straps, modes and live inputs.
  initial begin
    {nrst, op_enable, bus_mode_sel, signal_detect_enable, bus_cfg_we, clock_valid} = '0;
    {rate_above_2g, retimer_active, addr_drive, addr_val, m, a} = '0;
    ce = 1'b1;
    bus_cfg = retimer_cfg_pkg::BUS_CFG_RESET;
    sh = retimer_cfg_pkg::BUS_CFG_RESET;
    lvl = '{default: retimer_cfg_pkg::LVL_MID};
    void'($urandom(32'h0000_4978));
    repeat (20) @(posedge mclk);
    #1 check({power_down, rx_term_connect, dp_cfg}, {2'h3, retimer_cfg_pkg::DP_CFG_RESET});
    @(posedge mclk);
    nrst <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      m = (n < 6) ? n / 3 : $urandom_range(1);
      for (int k = 0; k < 4; k++) l[k] = (n < 6) ? n % 3 : $urandom_range(2);
      if (m && l[1] == 1) l[1] = 2 * $urandom_range(1);
      a = $urandom_range(1);
      @(posedge mclk);
      for (int k = 0; k < 4; k++) lvl[k] <= retimer_cfg_pkg::strap_lvl_type'(l[k]);
      bus_mode_sel <= m;
      addr_drive <= m;
      addr_val <= a;
      signal_detect_enable <= $urandom_range(1);
      clock_valid <= $urandom_range(1);
      rate_above_2g <= $urandom_range(1);
      retimer_active <= $urandom_range(1);
      op_enable <= 1'b1;
      repeat (5) @(posedge mclk);
      #1 check({dp_cfg, tx_term_on, strap_reserved, bus_mode, bus_addr_bits, power_down,
        detector_enable, standby, rx_term_connect}, expect_out());
      // Strap and mode changes after capture must be ignored.
      @(posedge mclk);
      for (int k = 0; k < 4; k++) lvl[k] <= retimer_cfg_pkg::strap_lvl_type'($urandom_range(2));
      bus_mode_sel <= !m;
      repeat (3) @(posedge mclk);
      #1 check({dp_cfg, tx_term_on, strap_reserved, bus_mode, bus_addr_bits},
        expect_out() >> 4);
      // Two back-to-back writes: the last one wins in bus mode, none lands in strap mode.
      for (int k = 0; k < 2; k++) begin
        @(posedge mclk);
        w.deemph = retimer_cfg_pkg::deemph_type'($urandom_range(1));
        w.eq_mode = retimer_cfg_pkg::eq_mode_type'($urandom_range(2));
        bus_cfg_we <= 1'b1;
        bus_cfg <= w;
      end
      @(posedge mclk);
      bus_cfg_we <= 1'b0;
      if (m) sh = w;
      repeat (3) @(posedge mclk);
      #1 check({dp_cfg, tx_term_on, strap_reserved, bus_mode, bus_addr_bits, power_down,
        detector_enable, standby, rx_term_connect}, expect_out());
      // Falling enable resets the device and powers it down.
      // On even passes the clock enable is low as the enable falls, so nothing may move yet.
      @(posedge mclk);
      op_enable <= 1'b0;
      ce <= n[0];
      if (!n[0]) begin
        repeat (2) @(posedge mclk);
        #1 check({power_down, device_reset_pulse, bus_mode}, {2'h0, m});
        @(posedge mclk);
        ce <= 1'b1;
      end
      @(posedge mclk);
      #1 check({14'h0, device_reset_pulse}, 15'h1);
      @(posedge mclk);
      #1 check({power_down, device_reset_pulse, detector_enable, tx_term_on, bus_mode, dp_cfg},
        {5'h10, retimer_cfg_pkg::DP_CFG_RESET});
      sh = retimer_cfg_pkg::BUS_CFG_RESET;
    end
    results();
  end
endmodule

// ===== dv/strap_board_model.sv
// Board side of the straps: resistor levels turned into pad sense bits.
// Assumes the bench picks a level per strap and whether the address pin is driven.
`timescale 1ns/100ps
module strap_board_model (
  // Clock for the open-pin pattern.
  input wire logic mclk,
  // Requested levels and address pin drive.
  input wire retimer_cfg_pkg::strap_lvl_type lvl [4],
  input wire logic addr_drive,
  input wire logic addr_val,
  // Pad sense and address pin.
  output retimer_cfg_pkg::strap_sense_type sense [4],
  output logic upper_addr_bit
);
  logic flip_r = 1'b0;

  // An open pin alternates between both mid patterns so no single one is relied on.
  always_ff @(posedge mclk) begin
    flip_r <= !flip_r;
  end

  // Pull to supply, pull to ground, or left open.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (lvl[i])
        retimer_cfg_pkg::LVL_HIGH: sense[i] = 2'h2;
        retimer_cfg_pkg::LVL_LOW: sense[i] = 2'h1;
        default: sense[i] = {flip_r, flip_r};
      endcase
    end
  end

  // The weak pull-down wins whenever the board leaves the pin open.
  assign upper_addr_bit = addr_drive ? addr_val : 1'b0;
endmodule
